// ===== core/mrr_pkg.sv
// package of the measurement result register bank: offsets, page codes, widths
// assumes byte-wide registers at byte offsets on an 8-bit register address
package mrr_pkg;
   localparam int        MRR_DATA_W       = 8;
   localparam logic [7:0] MRR_OFS_PAGE    = 8'h20;
   localparam logic [7:0] MRR_OFS_TRANS   = 8'h21;
   localparam logic [7:0] MRR_OFS_LEN_LO  = 8'h22;
   localparam logic [7:0] MRR_OFS_LEN_HI  = 8'h23;
   localparam logic [7:0] MRR_OFS_SEQ     = 8'h24;
   localparam logic [7:0] MRR_OFS_TEMP    = 8'h25;
   localparam logic [7:0] MRR_OFS_ZONES   = 8'h26;
   localparam logic [7:0] MRR_OFS_IR_B0   = 8'h28;
   localparam logic [7:0] MRR_OFS_IR_B1   = 8'h29;
   localparam logic [7:0] MRR_OFS_IR_B2   = 8'h2A;
   localparam logic [7:0] MRR_OFS_IR_B3   = 8'h2B;
   localparam logic [7:0] MRR_OFS_WT_B0   = 8'h2C;
   localparam logic [7:0] MRR_OFS_WT_B1   = 8'h2D;
   localparam logic [7:0] MRR_OFS_WT_B2   = 8'h2E;
   localparam logic [7:0] MRR_OFS_WT_B3   = 8'h2F;
   localparam logic [7:0] MRR_OFS_PAGED_LO = 8'h24;
   localparam logic [7:0] MRR_OFS_PAGED_HI = 8'hDF;
   localparam logic [7:0] MRR_APP_MEAS    = 8'h03;
   localparam logic [7:0] MRR_PAGE_MEAS   = 8'h10;
   localparam logic [7:0] MRR_RST_BYTE    = 8'h00;
   localparam logic [15:0] MRR_RST_HALF   = 16'h0000;
   localparam logic [31:0] MRR_RST_WORD   = 32'h0000_0000;
   localparam logic [7:0] MRR_ONE_BYTE    = 8'h01;
   localparam int        MRR_SUBCAP_W     = 2;
   localparam int        MRR_RUN_W        = 6;

   typedef struct packed {
      logic [7:0]  page;
      logic [7:0]  trans;
      logic [15:0] len;
      logic [7:0]  run_cnt;
      logic [7:0]  seq;
      logic [7:0]  temp;
      logic [7:0]  zones;
      logic [31:0] ir;
      logic [31:0] wt;
      logic [7:0]  rd_data;
      logic        rd_valid;
   } mrr_state_s;
endpackage : mrr_pkg

// ===== core/mrr_bank.sv
// register bank holding the packet header and the first measurement result fields
// assumes the result publisher and the page command arrive synchronous to clk_in,
// and that the serial host interface issues one byte read per rd_req_in pulse
//
// Function
// RL1: the transaction counter reads differently after every new transaction.
// RL2: the payload length is 16 bits, low byte at 0x22 and high byte at 0x23.
// RL3: offsets 0x24 upward read live data only with application 0x03 and page 0x10.
// RL4: the result sequence byte advances with every published record.
// RL5: in high-resolution mode the sequence byte carries sub-capture in 1:0, count in 7:2.
// RL6: die temperature is held as a signed byte in whole degrees.
// RL7: the count of zones with one or two results, no-target included, is a byte.
// RL8: the 32-bit ambient infrared sum reads least significant byte first at 0x28-0x2B.
// RL9: the 32-bit target weight reads least significant byte first from 0x2C.
// RL10: the page selector at 0x20 changes only by command and steers 0x24-0xDF.
// RL11: target weight bits 16-23 read at 0x2E and bits 24-31 at 0x2F.
// RL12: all fields reset to zero; all but the page selector update together when a record is published.
`timescale 1ns/100ps
module mrr_bank
   import mrr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // register read port
   input  wire logic              rd_req_in,
   input  wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [7:0]             rd_data_out,
   output logic                   rd_valid_out,
   // application and page command
   input  wire logic [7:0]        app_id_in,
   input  wire logic              page_cmd_in,
   input  wire logic [7:0]        page_val_in,
   // record publisher
   input  wire logic              pub_in,
   input  wire logic              hires_mode_in,
   input  wire logic [1:0]        pub_subcap_in,
   input  wire logic [15:0]       pub_len_in,
   input  wire logic [7:0]        pub_temp_in,
   input  wire logic [7:0]        pub_zones_in,
   input  wire logic [31:0]       pub_ir_in,
   input  wire logic [31:0]       pub_wt_in
);

   initial begin
      if (ADDR_W != 8) begin
         $error("mrr_bank serves an 8-bit register address only");
      end
   end

   mrr_state_s state_reg;
   mrr_state_s state_next;
   logic       page_live;
   logic [7:0] addr8;
   logic [7:0] run_inc;

   assign addr8     = rd_addr_in[7:0];
   assign page_live = (app_id_in == MRR_APP_MEAS) && (state_reg.page == MRR_PAGE_MEAS); // see RL3
   assign run_inc   = state_reg.run_cnt + MRR_ONE_BYTE;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next          = state_reg;
      state_next.rd_valid = rd_req_in;
      // page moves on a command only; there is no write path to it
      if (page_cmd_in) begin
         state_next.page = page_val_in; // see RL10
      end
      // the whole record swaps in one edge; a block read that spans that edge returns bytes of two records
      if (pub_in) begin
         state_next.trans   = state_reg.trans + MRR_ONE_BYTE; // see RL1
         state_next.len     = pub_len_in; // see RL2
         state_next.run_cnt = run_inc; // see RL4
         if (hires_mode_in) begin
            state_next.seq = {run_inc[MRR_RUN_W-1:0], pub_subcap_in}; // see RL5
         end else begin
            state_next.seq = run_inc; // see RL4
         end
         state_next.temp  = pub_temp_in; // see RL6
         state_next.zones = pub_zones_in; // see RL7
         state_next.ir    = pub_ir_in; // see RL8
         state_next.wt    = pub_wt_in; // see RL9
      end
      // reads see the record as it stood before a same-cycle publish
      state_next.rd_data = MRR_RST_BYTE;
      if (rd_req_in) begin
         case (addr8)
            MRR_OFS_PAGE:   state_next.rd_data = state_reg.page;
            MRR_OFS_TRANS:  state_next.rd_data = state_reg.trans;
            MRR_OFS_LEN_LO: state_next.rd_data = state_reg.len[7:0]; // see RL2
            MRR_OFS_LEN_HI: state_next.rd_data = state_reg.len[15:8]; // see RL2
            default:        state_next.rd_data = MRR_RST_BYTE;
         endcase
         if (page_live) begin // see RL3
            case (addr8)
               MRR_OFS_SEQ:   state_next.rd_data = state_reg.seq;
               MRR_OFS_TEMP:  state_next.rd_data = state_reg.temp;
               MRR_OFS_ZONES: state_next.rd_data = state_reg.zones;
               MRR_OFS_IR_B0: state_next.rd_data = state_reg.ir[7:0]; // see RL8
               MRR_OFS_IR_B1: state_next.rd_data = state_reg.ir[15:8];
               MRR_OFS_IR_B2: state_next.rd_data = state_reg.ir[23:16];
               MRR_OFS_IR_B3: state_next.rd_data = state_reg.ir[31:24];
               MRR_OFS_WT_B0: state_next.rd_data = state_reg.wt[7:0]; // see RL9
               MRR_OFS_WT_B1: state_next.rd_data = state_reg.wt[15:8];
               MRR_OFS_WT_B2: state_next.rd_data = state_reg.wt[23:16]; // see RL11
               MRR_OFS_WT_B3: state_next.rd_data = state_reg.wt[31:24]; // see RL11
               default:       state_next.rd_data = state_next.rd_data;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg.page     <= MRR_RST_BYTE; // see RL12
         state_reg.trans    <= MRR_RST_BYTE;
         state_reg.len      <= MRR_RST_HALF;
         state_reg.run_cnt  <= MRR_RST_BYTE;
         state_reg.seq      <= MRR_RST_BYTE;
         state_reg.temp     <= MRR_RST_BYTE;
         state_reg.zones    <= MRR_RST_BYTE;
         state_reg.ir       <= MRR_RST_WORD;
         state_reg.wt       <= MRR_RST_WORD;
         state_reg.rd_data  <= MRR_RST_BYTE;
         state_reg.rd_valid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_out  = state_reg.rd_data;
   assign rd_valid_out = state_reg.rd_valid;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking mrr_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   AST_TRANS_CHANGES: assert property (pub_in |=> state_reg.trans != $past(state_reg.trans)) // see RL1
      else $error("transaction counter did not change on publish");
   AST_LEN_HI_READ: assert property (rd_req_in && addr8 == MRR_OFS_LEN_HI
      |=> rd_valid_out && rd_data_out == $past(state_reg.len[15:8])) // see RL2
      else $error("payload length high byte read wrong");
   AST_PAGE_HIDDEN: assert property (rd_req_in && addr8 >= MRR_OFS_PAGED_LO && !page_live
      |=> rd_data_out == MRR_RST_BYTE) // see RL3
      else $error("paged field visible outside result page");
   AST_SEQ_ADVANCES: assert property (pub_in ##1 pub_in
      |=> state_reg.run_cnt == $past(state_reg.run_cnt, 2) + 8'h02) // see RL4
      else $error("sequence counter did not advance per record");
   AST_HIRES_SUBCAP: assert property (pub_in && hires_mode_in
      |=> state_reg.seq[1:0] == $past(pub_subcap_in)
          && state_reg.seq[7:2] == state_reg.run_cnt[5:0]) // see RL5
      else $error("high resolution sequence layout wrong");
   AST_TEMP_READ: assert property (rd_req_in && addr8 == MRR_OFS_TEMP && page_live
      |=> rd_data_out == $past(state_reg.temp)) // see RL6
      else $error("temperature read wrong");
   AST_ZONES_KEPT: assert property (pub_in |=> state_reg.zones == $past(pub_zones_in)) // see RL7
      else $error("zone count not captured");
   AST_IR_TOP_READ: assert property (rd_req_in && addr8 == MRR_OFS_IR_B3 && page_live
      |=> rd_data_out == $past(state_reg.ir[31:24])) // see RL8
      else $error("ambient top byte read wrong");
   AST_WT_LOW_READ: assert property (rd_req_in && addr8 == MRR_OFS_WT_B1 && page_live
      |=> rd_data_out == $past(state_reg.wt[15:8])) // see RL9
      else $error("weight byte 1 read wrong");
   AST_PAGE_CMD_ONLY: assert property (!page_cmd_in |=> $stable(state_reg.page)) // see RL10
      else $error("page changed without command");
   AST_WT_HIGH_READ: assert property (rd_req_in && addr8 == MRR_OFS_WT_B2 && page_live
      ##1 rd_req_in && addr8 == MRR_OFS_WT_B3 && page_live && !pub_in
      |=> rd_data_out == state_reg.wt[31:24]) // see RL11
      else $error("weight upper bytes read wrong");
   AST_RECORD_TOGETHER: assert property (pub_in |=> state_reg.ir == $past(pub_ir_in)
      && state_reg.wt == $past(pub_wt_in) && state_reg.len == $past(pub_len_in)
      && state_reg.temp == $past(pub_temp_in)) // see RL12
      else $error("record fields did not update together");

   COV_PUBLISH_READ: cover property (pub_in ##1 rd_req_in && addr8 == MRR_OFS_SEQ && page_live);
   COV_HIDDEN_READ: cover property (rd_req_in && addr8 == MRR_OFS_TEMP && !page_live);
   COV_PAGE_CMD: cover property (page_cmd_in && page_val_in == MRR_PAGE_MEAS);
   COV_HIRES: cover property (pub_in && hires_mode_in);

endmodule : mrr_bank

// ===== test/mrr_host.sv
// host model: byte reads on the register read port of the result bank
// assumes the bench calls rd from one process and drives nothing else here
`timescale 1ns/100ps
module mrr_host (
   // clock
   input  wire logic       clk_in,
   // read request side
   output logic            rd_req_out,
   output logic [7:0]      rd_addr_out,
   // read answer side
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in
);
   initial begin
      rd_req_out  = 1'b0;
      rd_addr_out = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one request cycle, answer sampled mid-cycle of the next one
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_in);
      rd_req_out  = 1'b1;
      rd_addr_out = a;
      @(negedge clk_in);
      rd_req_out  = 1'b0;
      // idle address is scrambled so a stale offset cannot pass unseen
      rd_addr_out = ~a;
      d           = rd_data_in;
      v           = rd_valid_in;
   endtask : rd
   // two requests on consecutive edges, each answer taken in the cycle it stands
   task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
      @(negedge clk_in);
      rd_req_out  = 1'b1;
      rd_addr_out = a;
      @(negedge clk_in);
      rd_addr_out = a + 8'h01;
      d0          = rd_data_in;
      @(negedge clk_in);
      rd_req_out  = 1'b0;
      rd_addr_out = ~a;
      d1          = rd_data_in;
   endtask : rd2
endmodule : mrr_host

// ===== test/testbench.sv
// bench of the result register bank: sweeps 0x20-0x30 after each event
// assumes the host model in mrr_host.sv and one clock domain
`timescale 1ns/100ps
module testbench;
   import mrr_pkg::*;
   logic        clk_in, rst_in, rd_req, rd_valid, page_cmd, pub, hires;
   logic [7:0]  rd_addr, rd_data, app, page_val, temp, zones, tr, run, page;
   logic [1:0]  sub;
   logic [15:0] len;
   logic [31:0] ir, wt;
   int          failures, n_compared;
   logic [7:0]  b0, b1;

   mrr_bank mrr_bank_i (.clk_in(clk_in), .rst_in(rst_in), .rd_req_in(rd_req),
      .rd_addr_in(rd_addr), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .app_id_in(app), .page_cmd_in(page_cmd), .page_val_in(page_val), .pub_in(pub),
      .hires_mode_in(hires), .pub_subcap_in(sub), .pub_len_in(len), .pub_temp_in(temp),
      .pub_zones_in(zones), .pub_ir_in(ir), .pub_wt_in(wt));
   mrr_host mrr_host_i (.clk_in(clk_in), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid));

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic test_done();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   function automatic logic [7:0] ex(input logic [7:0] a);
      logic [7:0] s;
      s = hires ? {run[5:0], sub} : run;
      if (a >= 8'h24 && !(app == MRR_APP_MEAS && page == MRR_PAGE_MEAS)) return 8'h00;
      case (a)
         8'h20: return page;
         8'h21: return tr;
         8'h22, 8'h23: return len[8*(a-8'h22) +: 8];
         8'h24: return s;
         8'h25: return temp;
         8'h26: return zones;
         8'h28, 8'h29, 8'h2A, 8'h2B: return ir[8*(a-8'h28) +: 8];
         8'h2C, 8'h2D, 8'h2E, 8'h2F: return wt[8*(a-8'h2C) +: 8];
         default: return 8'h00;
      endcase
   endfunction : ex
   task automatic sweep();
      logic [7:0] d;
      logic       v;
      for (int a = 32; a < 49; a++) begin
         mrr_host_i.rd(8'(a), d, v);
         check("valid", {7'h00, v}, 8'h01);
         check("byte", d, ex(8'(a)));
      end
   endtask : sweep
   task automatic pubr(input logic h, input logic [1:0] s, input logic [15:0] l,
                       input logic [7:0] t, z, input logic [31:0] i, w);
      @(negedge clk_in);
      {pub, hires, sub, len, temp, zones, ir, wt} = {1'b1, h, s, l, t, z, i, w};
      @(negedge clk_in);
      pub = 1'b0;
      tr++;
      run++;
   endtask : pubr
   task automatic pgc(input logic [7:0] v);
      @(negedge clk_in);
      page_cmd = 1'b1;
      page_val = v;
      @(negedge clk_in);
      page_cmd = 1'b0;
      page     = v;
   endtask : pgc
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {failures, n_compared, tr, run, page, page_val} = '0;
      {pub, page_cmd, hires, sub, len, temp, zones, ir, wt} = '0;
      rst_in = 1'b1;
      app    = MRR_APP_MEAS;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in) rst_in = 1'b0;
      sweep();
      pgc(MRR_PAGE_MEAS);
      sweep();
      pubr(1'b0, 2'h0, 16'h01A4, 8'hF6, 8'h40, 32'h89AB_CDEF, 32'h1234_5678);
      sweep();
      pubr(1'b1, 2'h2, 16'hFF00, 8'h7F, 8'h00, 32'h0102_0304, 32'hFEDC_BA98);
      sweep();
      mrr_host_i.rd2(MRR_OFS_WT_B2, b0, b1);
      check("weight b2 burst", b0, wt[23:16]);
      check("weight b3 burst", b1, wt[31:24]);
      // two records on consecutive edges: the later one must stand whole
      @(negedge clk_in);
      {pub, sub, temp} = {1'b1, 2'h3, 8'h80};
      @(negedge clk_in);
      {sub, temp} = {2'h1, 8'h81};
      @(negedge clk_in);
      pub = 1'b0;
      tr += 8'h02;
      run += 8'h02;
      sweep();
      app = 8'h02;
      sweep();
      app = MRR_APP_MEAS;
      pgc(8'h16);
      sweep();
      test_done();
   end
   // sweeps need about 270 cycles; the limit leaves wide margin
   initial begin
      #(8 * 4000);
      failures++;
      test_done();
   end
endmodule : testbench
